// ==== sab_pkg.sv ====
// Purpose: shared constants for the multiplexed host bus port
// Assumes: one clock at 100 MHz, bus levels are active low
// Notes: address byte = select code in bits 7..3, register in 2..0
package sab_pkg;
  // ****************************************
  // bus layout
  // ****************************************
  localparam int BUS_W = 8; // shared lines width
  localparam int SEL_W = 5; // hard-wired select code width
  localparam int SEL_LSB = 3; // select code position in address
  localparam int REG_W = 3; // register index width
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [2:0] REG_DATA = 3'h0; // rx read / tx write
  localparam logic [2:0] REG_STATUS = 3'h1; // status, read only
  localparam logic [2:0] REG_CTRL1 = 3'h2; // modem and irq enables
  localparam logic [2:0] REG_CTRL2 = 3'h3; // mode byte for engines
  // ****************************************
  // control 1 fields
  // ****************************************
  localparam int C1_DTR = 0; // terminal ready on
  localparam int C1_SPARE = 1; // spare output on
  localparam int C1_TXIE = 2; // tx empty raises irq
  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_RXRDY = 0; // received byte waiting
  localparam int ST_TXEMPTY = 1; // tx holding free
  localparam int ST_RING = 2; // ring seen with dtr off
  localparam int ST_OVERRUN = 3; // rx byte lost
  localparam int ST_RINGLVL = 4; // ring line on now
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00; // controls cleared
  localparam logic [7:0] DATA_RST = 8'h00; // data cleared
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10; // 100 MHz
  localparam int REPLY_WAIT_NS = 160; // host gives up after this
  localparam int REPLY_WAIT_CYC = REPLY_WAIT_NS / CLK_PERIOD_NS;
  localparam int WAIT_W = 5; // counter width for the wait
endpackage : sab_pkg

// ==== sab_bus_if.sv ====
// Purpose: wires between host and device ends of the shared bus
// Assumes: pull-ups on every line, open-drain reply and irq
// Notes: resolves wire levels from the enables
`timescale 1ns/1ps
interface sab_bus_if;
  // host driven strobes, all active low
  logic csN;
  logic reN;
  logic weN;
  logic pollInN;
  logic chipClearN;
  // shared lines, one driver pair per end
  logic [7:0] hostOut;
  logic hostOe;
  logic [7:0] devOut;
  logic devOe;
  logic [7:0] dal;
  // open-drain lines from the device
  logic replyOut;
  logic replyOe;
  logic irqOut;
  logic irqOe;
  logic replyN;
  logic irqN;
  // chain output toward the next device
  logic pollOutN;

  // pulled high when nobody drives
  assign dal = devOe ? devOut : (hostOe ? hostOut : 8'hFF);
  assign replyN = replyOe ? replyOut : 1'b1;
  assign irqN = irqOe ? irqOut : 1'b1;

  modport host (output csN, reN, weN, pollInN, chipClearN, hostOut,
    hostOe, input dal, replyN, irqN, pollOutN);
  modport device (input csN, reN, weN, pollInN, chipClearN, dal,
    output devOut, devOe, replyOut, replyOe, irqOut, irqOe, pollOutN);
endinterface : sab_bus_if

// ==== sab_device_port.sv ====
// Purpose: device end of the multiplexed active-low host bus
// Assumes: strobes synchronous to clk, engines sit on the user side
// Notes: reply and shared-line drive come from flip-flops
// How it works
// - every bus and modem line is active low
// - eight shared lines carry address, data, id
// - select falling edge latches the address
// - write strobe low loads addressed register
// - answer only when address matches select code
// - reply low when selected with read or write strobe low, or poll winner
// - irq line low while any condition active
// - poll in low and requesting: drive id
// - poll in low, not requesting: chain out low
// - terminal ready follows control bit
// - ring low with terminal ready off interrupts
// - spare output follows control bit
// - read strobe low drives addressed register out
// - master clear low clears controls and flags, data bytes kept
`timescale 1ns/1ps
module sab_device_port (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus side
  sab_bus_if.device bus,
  // identity straps, active low
  input wire logic [4:0] selectCodePins_n,
  // receive engine side
  input wire logic [7:0] rxData,
  input wire logic rxStrobe,
  // transmit engine side
  output logic [7:0] txData,
  output logic txFull,
  input wire logic txTake,
  // modem lines, active low
  input wire logic ring_n,
  output logic dtr_n,
  output logic spare_n,
  // mode byte for engines
  output logic [7:0] modeCtrl
);
  // ****************************************
  // edge detection and internal state
  // ****************************************
  logic csPrev; // last sampled select
  logic rePrev; // last sampled read strobe
  logic wePrev; // last sampled write strobe
  logic ringPrev; // last sampled ring line
  logic selected; // address matched, cs still low
  logic [2:0] regIdx; // latched register index
  logic [7:0] rxHold; // received byte
  logic rxReady; // byte waiting
  logic overrun; // byte lost
  logic ringFlag; // ring event pending
  logic [7:0] ctrl1; // modem bits and enables
  logic [7:0] ctrl2; // mode byte
  logic [7:0] busOut; // registered line drive
  logic busOe; // registered line enable
  logic replyOe; // registered reply drive
  logic pollOut; // registered chain output, active high here

  // ****************************************
  // decode
  // ****************************************
  wire [7:0] dalVal = ~bus.dal;
  wire [4:0] selCode = ~selectCodePins_n;
  wire csFall = csPrev & ~bus.csN;
  wire addrHit = dalVal[7:sab_pkg::SEL_LSB] == selCode;
  wire selLive = selected & ~bus.csN;
  wire writeFall = selLive & wePrev & ~bus.weN;
  wire readFall = selLive & rePrev & ~bus.reN;
  wire readLive = selLive & ~bus.reN;
  wire writeLive = selLive & ~bus.weN;
  wire dtrOn = ctrl1[sab_pkg::C1_DTR];
  wire ringFall = ringPrev & ~ring_n & ~dtrOn;
  wire txIrq = ~txFull & ctrl1[sab_pkg::C1_TXIE];
  wire irqActive = rxReady | ringFlag | overrun | txIrq;
  wire pollLive = ~bus.pollInN;
  wire pollMine = pollLive & irqActive;
  wire pollPass = pollLive & ~irqActive;
  wire [7:0] idByte = {selCode, 3'h0};
  wire clearNow = ~bus.chipClearN;
  wire rdData = readFall & (regIdx == sab_pkg::REG_DATA);
  wire rdStatus = readFall & (regIdx == sab_pkg::REG_STATUS);
  wire wrData = writeFall & (regIdx == sab_pkg::REG_DATA);
  wire wrCtrl1 = writeFall & (regIdx == sab_pkg::REG_CTRL1);
  wire wrCtrl2 = writeFall & (regIdx == sab_pkg::REG_CTRL2);

  // status byte, unused bits read zero
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[sab_pkg::ST_RXRDY] = rxReady;
    statusByte[sab_pkg::ST_TXEMPTY] = ~txFull;
    statusByte[sab_pkg::ST_RING] = ringFlag;
    statusByte[sab_pkg::ST_OVERRUN] = overrun;
    statusByte[sab_pkg::ST_RINGLVL] = ~ring_n;
  end

  // read mux, unmapped indices read zero
  logic [7:0] rdMux;
  always_comb begin
    unique case (regIdx)
      sab_pkg::REG_DATA: rdMux = rxHold;
      sab_pkg::REG_STATUS: rdMux = statusByte;
      sab_pkg::REG_CTRL1: rdMux = ctrl1;
      sab_pkg::REG_CTRL2: rdMux = ctrl2;
      default: rdMux = 8'h00; // other indices unmapped
    endcase
  end

  // ****************************************
  // strobe history
  // ****************************************
  // idle levels after reset so no false edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      csPrev <= 1'b1;
      rePrev <= 1'b1;
      wePrev <= 1'b1;
      ringPrev <= 1'b1;
    end else begin
      csPrev <= bus.csN;
      rePrev <= bus.reN;
      wePrev <= bus.weN;
      ringPrev <= ring_n;
    end
  end

  // ****************************************
  // address phase
  // ****************************************
  // select held only while cs stays low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selected <= 1'b0;
      regIdx <= 3'h0;
    end else if (csFall) begin
      selected <= addrHit;
      regIdx <= dalVal[2:0];
    end else if (bus.csN) begin
      selected <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl1 <= sab_pkg::CTRL_RST;
      ctrl2 <= sab_pkg::CTRL_RST;
    end else if (clearNow) begin
      ctrl1 <= sab_pkg::CTRL_RST;
      ctrl2 <= sab_pkg::CTRL_RST;
    end else begin
      if (wrCtrl1) begin
        ctrl1 <= dalVal;
      end
      if (wrCtrl2) begin
        ctrl2 <= dalVal;
      end
    end
  end

  // ****************************************
  // transmit holding
  // ****************************************
  // a write in the take cycle wins, byte is not lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txData <= sab_pkg::DATA_RST;
      txFull <= 1'b0;
    end else if (clearNow) begin
      txFull <= 1'b0;
    end else if (wrData) begin
      txData <= dalVal;
      txFull <= 1'b1;
    end else if (txTake) begin
      txFull <= 1'b0;
    end
  end

  // ****************************************
  // receive holding and flags
  // ****************************************
  // hardware set beats a read-clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxHold <= sab_pkg::DATA_RST;
      rxReady <= 1'b0;
      overrun <= 1'b0;
    end else if (clearNow) begin
      rxReady <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (rxStrobe) begin
        rxHold <= rxData;
        rxReady <= 1'b1;
      end else if (rdData) begin
        rxReady <= 1'b0;
      end
      if (rxStrobe & rxReady & ~rdData) begin
        overrun <= 1'b1;
      end else if (rdStatus) begin
        overrun <= 1'b0;
      end
    end
  end

  // ring event sticks until status is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ringFlag <= 1'b0;
    end else if (clearNow) begin
      ringFlag <= 1'b0;
    end else if (ringFall) begin
      ringFlag <= 1'b1;
    end else if (rdStatus) begin
      ringFlag <= 1'b0;
    end
  end

  // ****************************************
  // bus drive, reply and chain
  // ****************************************
  // registered so data and reply change on the same edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busOut <= 8'h00;
      busOe <= 1'b0;
      replyOe <= 1'b0;
      pollOut <= 1'b0;
    end else begin
      busOe <= readLive | pollMine;
      busOut <= pollMine ? idByte : rdMux;
      replyOe <= readLive | writeLive | pollMine;
      pollOut <= pollPass;
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  assign bus.devOut = ~busOut;
  assign bus.devOe = busOe;
  assign bus.replyOut = 1'b0; // open drain only pulls low
  assign bus.replyOe = replyOe;
  assign bus.irqOut = 1'b0;
  assign bus.irqOe = irqActive;
  assign bus.pollOutN = ~pollOut;
  assign dtr_n = ~dtrOn;
  assign spare_n = ~ctrl1[sab_pkg::C1_SPARE];
  assign modeCtrl = ctrl2;
endmodule : sab_device_port

// ==== sab_host_port.sv ====
// Purpose: host end of the multiplexed active-low device bus
// Assumes: one device or a chain on the same wires
// Notes: one command at a time, replies waited with a timeout
`timescale 1ns/1ps
module sab_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus side
  sab_bus_if.host bus,
  // command port
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdPoll,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  output logic cmdReady,
  // answer port
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspNoReply,
  // misc
  input wire logic clearDevice,
  output logic irqPending
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    H_IDLE, H_ADDR, H_SEL, H_DATA, H_STROBE, H_POLL, H_DONE
  } sab_hstate_t;
  sab_hstate_t state; // current phase
  logic isWrite; // command is a write
  logic [7:0] addr; // latched address byte
  logic [7:0] wdata; // latched write byte
  logic [sab_pkg::WAIT_W-1:0] waitCnt; // reply timeout
  logic clearReg; // registered master clear

  localparam logic [sab_pkg::WAIT_W-1:0] WAIT_MAX =
    sab_pkg::WAIT_W'(sab_pkg::REPLY_WAIT_CYC - 1);

  wire take = cmdValid & cmdReady;
  wire replied = ~bus.replyN;
  wire timedOut = waitCnt == WAIT_MAX;
  wire waiting = state == H_STROBE || state == H_POLL;

  // ****************************************
  // sequencer
  // ****************************************
  // address, select, data, strobe, release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= H_IDLE;
    end else begin
      unique case (state)
        H_IDLE: if (take) state <= cmdPoll ? H_POLL : H_ADDR;
        H_ADDR: state <= H_SEL;
        H_SEL: state <= H_DATA;
        H_DATA: state <= H_STROBE;
        H_STROBE: if (replied || timedOut) state <= H_DONE;
        H_POLL: begin
          if (replied || ~bus.pollOutN || timedOut) state <= H_DONE;
        end
        H_DONE: state <= H_IDLE; // lets device release first
      endcase
    end
  end

  // command latch and wait counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      isWrite <= 1'b0;
      addr <= 8'h00;
      wdata <= 8'h00;
      waitCnt <= '0;
    end else begin
      if (take) begin
        isWrite <= cmdWrite;
        addr <= cmdAddr;
        wdata <= cmdData;
      end
      waitCnt <= waiting ? waitCnt + 1'b1 : '0;
    end
  end

  // answer capture, a one-cycle pulse on entering done
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rspData <= 8'h00;
      rspNoReply <= 1'b0;
      clearReg <= 1'b1;
    end else begin
      rspValid <= waiting & (replied | timedOut | ~bus.pollOutN);
      if (waiting & (replied | timedOut | ~bus.pollOutN)) begin
        rspData <= replied & ~isWrite ? ~bus.dal : 8'h00;
        rspNoReply <= ~replied;
      end
      clearReg <= clearDevice;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  wire selPhase = state == H_SEL || state == H_DATA || state == H_STROBE;
  assign bus.csN = ~selPhase;
  assign bus.weN = ~(state == H_STROBE && isWrite);
  assign bus.reN = ~(state == H_STROBE && ~isWrite);
  assign bus.pollInN = ~(state == H_POLL);
  assign bus.chipClearN = ~clearReg;
  assign bus.hostOe = state == H_ADDR || state == H_SEL ||
    (isWrite && (state == H_DATA || state == H_STROBE));
  assign bus.hostOut = (state == H_ADDR || state == H_SEL) ? ~addr :
    ~wdata;
  assign cmdReady = state == H_IDLE;
  assign irqPending = ~bus.irqN;
endmodule : sab_host_port

// ==== sab_bus_assertions.sv ====
// Purpose: protocol checks on the wires between host and device
// Assumes: one device at the chain end, dal carries inverted values
// Notes: CODE must equal the strapped select code
`timescale 1ns/1ps
module sab_bus_assertions #(
  parameter logic [4:0] CODE = 5'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host side levels
  input wire logic csN,
  input wire logic reN,
  input wire logic weN,
  input wire logic pollInN,
  input wire logic hostOe,
  input wire logic chipClearN,
  // device side drive
  input wire logic devOe,
  input wire logic [7:0] dal,
  input wire logic replyOut,
  input wire logic replyOe,
  input wire logic irqOut,
  input wire logic irqOe,
  input wire logic pollOutN
);
  // ********
  // address match tracking
  // ********
  logic csPrev; // select level one edge ago
  logic hit; // latched address carried our code
  wire logic [4:0] wireCode = ~dal[7:3]; // code field, wire is inverted
  // latch at the select fall, same edge as the device
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      csPrev <= 1'b1;
      hit <= 1'b0;
    end else begin
      csPrev <= csN;
      if (!csN && csPrev) begin
        hit <= (wireCode == CODE);
      end
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  reply_open_drain_a: assert property (replyOe |-> !replyOut)
    else $error("reply drives high");
  irq_open_drain_a: assert property (irqOe |-> !irqOut)
    else $error("irq drives high");
  // irq may only drop after an access or a master clear
  irq_hold_a: assert property ($fell(irqOe) |->
    $past(!csN) || $past(!chipClearN))
    else $error("irq dropped without service");
  no_contention_a: assert property (!(devOe && hostOe))
    else $error("both ends drive the lines");
  reply_cause_a: assert property (replyOe |->
    $past(!csN && (!reN || !weN)) || $past(!pollInN))
    else $error("reply without strobe");
  drive_cause_a: assert property (devOe |->
    $past(!csN && !reN) || $past(!pollInN))
    else $error("device drives without read");
  read_reply_a: assert property ($fell(reN) && !csN && hit |=>
    devOe && replyOe) else $error("read not answered");
  write_reply_a: assert property ($fell(weN) && !csN && hit |=>
    replyOe && !devOe) else $error("write not answered");
  foreign_code_a: assert property (!csN && !csPrev && !hit |->
    !replyOe) else $error("reply to foreign code");
  strobe_release_a: assert property ($rose(csN) |=>
    !replyOe && !devOe) else $error("bus kept after select");
  chain_pass_a: assert property ((!pollInN && !irqOe) [*2] |=>
    !pollOutN) else $error("poll not passed on");
  chain_hold_a: assert property (!pollOutN |-> $past(!pollInN))
    else $error("chain out without poll");
  poll_id_a: assert property ((!pollInN && irqOe) [*2] |=>
    devOe && replyOe && pollOutN && dal == ~{CODE, 3'h0})
    else $error("poll id wrong");
  // main scenarios reached
  read_seen_c: cover property ($fell(reN) && !csN && hit);
  poll_id_c: cover property ((!pollInN && irqOe) [*2]);
  poll_pass_c: cover property ((!pollInN && !irqOe) [*2]);
endmodule : sab_bus_assertions

// ==== tb_top.sv ====
// Purpose: end-to-end test of the host and device bus ports
// Assumes: one device strapped to CODE, host at the other end
// Notes: expectations follow the register map of the package
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errTotal++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [4:0] CODE = 5'h15; // arbitrary strap value
  // ********
  // stimulus and observation
  // ********
  logic clk = 1'b0; // 100 MHz clock
  logic sysRst = 1'b1; // async reset, high
  logic cmdValid = 1'b0, cmdWrite = 1'b0, cmdPoll = 1'b0, cmdReady;
  logic [7:0] cmdAddr = 8'h00, cmdData = 8'h00, rspData, rxData = 8'h00;
  logic rspValid, rspNoReply, irqPending, rxStrobe = 1'b0, txFull;
  logic clearDevice = 1'b0, txTake = 1'b0, ringN = 1'b1, dtrN, spareN;
  logic [7:0] txData, modeCtrl; // engine side outputs
  int errTotal = 0; // mismatches
  int nTests = 0; // comparisons
  always #5 clk = ~clk;
  sab_bus_if busIf();
  sab_host_port i_sab_host_port (.clk(clk), .sys_rst(sysRst), .bus(busIf),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdPoll(cmdPoll),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspNoReply(rspNoReply),
    .clearDevice(clearDevice), .irqPending(irqPending));
  sab_device_port i_sab_device_port (.clk(clk), .sys_rst(sysRst),
    .bus(busIf), .selectCodePins_n(~CODE), .rxData(rxData),
    .rxStrobe(rxStrobe), .txData(txData), .txFull(txFull),
    .txTake(txTake), .ring_n(ringN), .dtr_n(dtrN), .spare_n(spareN),
    .modeCtrl(modeCtrl));
  sab_bus_assertions #(.CODE(CODE)) i_sab_bus_assertions (.clk(clk),
    .sys_rst(sysRst), .csN(busIf.csN), .reN(busIf.reN),
    .weN(busIf.weN), .pollInN(busIf.pollInN), .hostOe(busIf.hostOe),
    .chipClearN(busIf.chipClearN),
    .devOe(busIf.devOe), .dal(busIf.dal), .replyOut(busIf.replyOut),
    .replyOe(busIf.replyOe), .irqOut(busIf.irqOut),
    .irqOe(busIf.irqOe), .pollOutN(busIf.pollOutN));
  // ********
  // tasks
  // ********
  // verdict, also reached when a wait runs out
  task automatic conclude();
    $display("checks %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // bounded wait on ready or answer, a lapse is a mismatch
  task automatic await(input bit onRsp);
    int i;
    i = 0;
    while ((onRsp ? rspValid : cmdReady) !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    if ((onRsp ? rspValid : cmdReady) !== 1'b1) begin
      errTotal++;
      $display("[FAIL] %0t wait for host ran out", $time);
      conclude();
    end
  endtask : await
  // one host command, held until taken, then its answer
  task automatic cmd(input logic w, input logic p, input logic [7:0] a,
    input logic [7:0] d);
    await(1'b0);
    {cmdValid, cmdWrite, cmdPoll, cmdAddr, cmdData} = {1'b1, w, p, a, d};
    tick(1);
    cmdValid = 1'b0;
    await(1'b1);
  endtask : cmd
  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    cmd(1'b1, 1'b0, {CODE, r}, d);
  endtask : wr
  task automatic rdChk(input logic [2:0] r, input logic [7:0] e);
    cmd(1'b0, 1'b0, {CODE, r}, 8'h00);
    `CHK({rspNoReply, rspData}, {1'b0, e})
  endtask : rdChk
  // ********
  // scenarios
  // ********
  initial begin
    tick(3);
    sysRst = 1'b0;
    tick(2);
    `CHK({dtrN, spareN, txFull, irqPending}, 4'hC)
    rdChk(sab_pkg::REG_CTRL1, 8'h00);
    rdChk(sab_pkg::REG_STATUS, 8'h02);
    $display("test reset done");
    wr(sab_pkg::REG_CTRL1, 8'h01);
    `CHK({dtrN, spareN}, 2'b01)
    wr(sab_pkg::REG_CTRL1, 8'h02);
    `CHK({dtrN, spareN}, 2'b10)
    rdChk(sab_pkg::REG_CTRL1, 8'h02);
    wr(sab_pkg::REG_CTRL2, 8'hA5);
    rdChk(sab_pkg::REG_CTRL2, 8'hA5);
    rdChk(3'h5, 8'h00);
    cmd(1'b1, 1'b0, {~CODE, sab_pkg::REG_CTRL2}, 8'h3C);
    `CHK({rspNoReply, modeCtrl}, 9'h1A5)
    $display("test registers done");
    wr(sab_pkg::REG_DATA, 8'h3C);
    `CHK({txFull, txData}, 9'h13C)
    rdChk(sab_pkg::REG_STATUS, 8'h00);
    txTake = 1'b1;
    tick(1);
    txTake = 1'b0;
    tick(1);
    `CHK(txFull, 1'b0)
    {rxData, rxStrobe} = {8'h5A, 1'b1};
    tick(1);
    rxStrobe = 1'b0;
    tick(2);
    `CHK(irqPending, 1'b1)
    cmd(1'b0, 1'b1, 8'h00, 8'h00);
    `CHK({rspNoReply, rspData}, {1'b0, CODE, 3'h0})
    rdChk(sab_pkg::REG_STATUS, 8'h03);
    rdChk(sab_pkg::REG_DATA, 8'h5A);
    tick(2);
    `CHK(irqPending, 1'b0)
    cmd(1'b0, 1'b1, 8'h00, 8'h00);
    `CHK(rspNoReply, 1'b1)
    // two bytes with no read between: the first is lost
    {rxData, rxStrobe} = {8'h11, 1'b1};
    tick(1);
    rxData = 8'h22;
    tick(1);
    rxStrobe = 1'b0;
    tick(1);
    rdChk(sab_pkg::REG_STATUS, 8'h0B);
    rdChk(sab_pkg::REG_DATA, 8'h22);
    `CHK(irqPending, 1'b0)
    $display("test data and poll done");
    wr(sab_pkg::REG_CTRL1, 8'h00);
    ringN = 1'b0;
    tick(3);
    `CHK(irqPending, 1'b1)
    rdChk(sab_pkg::REG_STATUS, 8'h16);
    ringN = 1'b1;
    tick(2);
    rdChk(sab_pkg::REG_STATUS, 8'h02);
    `CHK(irqPending, 1'b0)
    wr(sab_pkg::REG_CTRL1, 8'h01);
    ringN = 1'b0;
    tick(3);
    `CHK(irqPending, 1'b0)
    ringN = 1'b1;
    wr(sab_pkg::REG_CTRL1, 8'h07);
    tick(2);
    `CHK({irqPending, dtrN, spareN}, 3'b100)
    $display("test ring done");
    clearDevice = 1'b1;
    tick(3);
    `CHK({dtrN, spareN, modeCtrl}, 10'h300)
    clearDevice = 1'b0;
    tick(2);
    rdChk(sab_pkg::REG_CTRL1, 8'h00);
    $display("test clear done");
    conclude();
  end
endmodule : tb_top
